// ### rtl/usc_pkg.sv
// Constants for the USB supply source control block.
// Assumes a classic Wishbone slave, 32-bit data, one 250 MHz clock.
package usc_pkg;

	// ------------------------------------------------------------
	// Bus layout
	// ------------------------------------------------------------
	localparam int          ADR_W        = 4;
	localparam logic [3:0]  OFS_CTRL     = 4'h0;
	localparam logic [3:0]  OFS_STATUS   = 4'h4;
	localparam logic [3:0]  OFS_IRQ_STAT = 4'h8;
	localparam logic [3:0]  OFS_IRQ_MASK = 4'hC;

	// ------------------------------------------------------------
	// Control register fields
	// ------------------------------------------------------------
	localparam int B_SRC_SEL  = 0;
	localparam int B_LDO_EN   = 1;
	localparam int B_BOOST_EN = 2;
	localparam int B_AUX_VLO  = 3;
	localparam int B_AUX_VHI  = 4;
	localparam int B_AUX_EN   = 5;
	localparam int B_CHG_MAN  = 6;
	localparam int B_CHG_ILO  = 8;
	localparam int B_CHG_IHI  = 11;
	localparam int CHG_I_W    = 4;

	// ------------------------------------------------------------
	// Status and interrupt fields
	// ------------------------------------------------------------
	localparam int N_IN       = 5;
	localparam int I_BUS_OK   = 0;
	localparam int I_SESS_OK  = 1;
	localparam int I_OVV      = 2;
	localparam int I_STRAP    = 3;
	localparam int I_DRIVE    = 4;
	localparam int B_SW_CLOSE = 5;
	localparam int B_LDO_ON   = 6;
	localparam int B_RUN      = 7;
	localparam int N_IRQ      = 4;
	localparam int Q_BUS_RISE = 0;
	localparam int Q_BUS_FALL = 1;
	localparam int Q_SESS_UP  = 2;
	localparam int Q_OVV_UP   = 3;

	// ------------------------------------------------------------
	// Aux LDO voltage codes
	// ------------------------------------------------------------
	localparam logic [1:0] AUX_2V400 = 2'h0;
	localparam logic [1:0] AUX_2V600 = 2'h1;
	localparam logic [1:0] AUX_2V700 = 2'h2;
	localparam logic [1:0] AUX_2V775 = 2'h3;
	localparam logic [1:0] AUX_RST   = AUX_2V400;

	// ------------------------------------------------------------
	// Start-up sequencing
	// ------------------------------------------------------------
	localparam logic [1:0] SETTLE_CYC = 2'h3;
	localparam logic [1:0] SETTLE_0   = 2'h0;
	localparam logic [1:0] SETTLE_1   = 2'h1;

	typedef enum logic [1:0] {
		ST_COLD,
		ST_SETTLE,
		ST_LOAD,
		ST_RUN
	} usc_state_t;

endpackage

// ### rtl/usc_top.sv
// USB supply source control: PHY LDO source select, boost-to-bus
// switch, strap defaults, auto enables, over-voltage cut and aux LDO.
// Assumes pins come from outside the clock domain and are synchronised
// here; registers sit behind a classic Wishbone slave.
`timescale 1ns/10ps
module usc_top (
	// Clock, reset, clock enable
	input  wire logic                        clk_i,
	input  wire logic                        rst_i,
	input  wire logic                        ce_i,
	// Wishbone slave
	input  wire logic                        cyc_i,
	input  wire logic                        stb_i,
	input  wire logic                        we_i,
	input  wire logic [usc_pkg::ADR_W-1:0]   adr_i,
	input  wire logic [3:0]                  sel_i,
	input  wire logic [31:0]                 dat_i,
	output logic      [31:0]                 dat_o,
	output logic                             ack_o,
	// Pins and comparators
	input  wire logic                        cable_bus_valid_i,
	input  wire logic                        session_valid_i,
	input  wire logic                        bus_overvoltage_i,
	input  wire logic                        power_up_strap_two_gnd_i,
	input  wire logic                        bus_drive_enable_pin_i,
	input  wire logic                        system_reset_n_i,
	// Supply controls
	output logic                             phy_ldo_src_boost_o,
	output logic                             phy_ldo_on_o,
	output logic                             boost_switch_close_o,
	output logic                             boost_converter_en_o,
	output logic                             aux_phy_ldo_on_o,
	output logic [1:0]                       aux_ldo_voltage_select_o,
	output logic                             charger_manual_mode_o,
	output logic [usc_pkg::CHG_I_W-1:0]      charge_current_o,
	// Interrupt
	output logic                             irq_o
);
	import usc_pkg::*;

	// ------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------
	logic [N_IN-1:0] pin_vec;
	logic [N_IN-1:0] sync_a;
	logic [N_IN-1:0] sync_b;
	logic [N_IN-1:0] sync_prev;
	logic            rstn_a;
	logic            rstn_b;

	assign pin_vec[I_BUS_OK]  = cable_bus_valid_i;
	assign pin_vec[I_SESS_OK] = session_valid_i;
	assign pin_vec[I_OVV]     = bus_overvoltage_i;
	assign pin_vec[I_STRAP]   = power_up_strap_two_gnd_i;
	assign pin_vec[I_DRIVE]   = bus_drive_enable_pin_i;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sync_a    <= '0;
			sync_b    <= '0;
			sync_prev <= '0;
			rstn_a    <= 1'b0;
			rstn_b    <= 1'b0;
		end else if (ce_i) begin
			sync_a    <= pin_vec;
			sync_b    <= sync_a;
			sync_prev <= sync_b;
			rstn_a    <= system_reset_n_i;
			rstn_b    <= rstn_a;
		end
	end

	wire bus_ok  = sync_b[I_BUS_OK];
	wire sess_ok = sync_b[I_SESS_OK];
	wire ovv     = sync_b[I_OVV];
	wire strap   = sync_b[I_STRAP];
	wire drive   = sync_b[I_DRIVE];

	// ------------------------------------------------------------
	// Start-up sequencer
	// ------------------------------------------------------------
	usc_state_t state;
	usc_state_t next_state;
	logic [1:0] settle;
	logic       strap_gnd;

	always_comb begin
		next_state = state;
		case (state)
			ST_COLD: begin
				next_state = ST_SETTLE;
			end
			ST_SETTLE: begin
				if (settle == SETTLE_CYC)
					next_state = ST_LOAD;
			end
			ST_LOAD: begin
				next_state = ST_RUN;
			end
			ST_RUN: begin
				next_state = ST_RUN;
			end
			default: begin
				next_state = ST_COLD;
			end
		endcase
	end

	wire running = (state == ST_RUN);
	wire loading = (state == ST_LOAD);

	// Strap is caught from the synchronised pin, never under reset
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state     <= ST_COLD;
			settle    <= SETTLE_0;
			strap_gnd <= 1'b0;
		end else if (ce_i) begin
			state <= next_state;
			if (state == ST_SETTLE)
				settle <= settle + SETTLE_1;
			if (loading)
				strap_gnd <= strap;
		end
	end

	// ------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------
	logic ack;
	wire  req      = cyc_i & stb_i;
	wire  commit   = req & ack & ce_i;
	wire  wr       = commit & we_i;
	wire  rd       = commit & ~we_i;
	wire  hit_ctrl = (adr_i == OFS_CTRL);
	wire  hit_stat = (adr_i == OFS_STATUS);
	wire  hit_irqs = (adr_i == OFS_IRQ_STAT);
	wire  hit_irqm = (adr_i == OFS_IRQ_MASK);
	wire  wr_ctrl0 = wr & hit_ctrl & sel_i[0];
	wire  wr_ctrl1 = wr & hit_ctrl & sel_i[1];
	wire  wr_irqm  = wr & hit_irqm & sel_i[0];
	wire  rd_irqs  = rd & hit_irqs;

	// ------------------------------------------------------------
	// Control register
	// ------------------------------------------------------------
	logic               src_sel;
	logic               ldo_en;
	logic               boost_en;
	logic [1:0]         aux_vsel;
	logic               aux_en;
	logic               chg_man;
	logic [CHG_I_W-1:0] chg_i;

	wire w_src = dat_i[B_SRC_SEL];
	// Setting OTG mode turns on both USB regulators; rewriting a 1 does
	// not, so software can still clear the enable before a host handover
	wire otg_req = wr_ctrl0 & w_src & ~src_sel;
	// Strap open: enable snaps back on reset or bus loss
	wire force_en = ~strap_gnd & (~rstn_b | ~bus_ok);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			src_sel  <= 1'b0;
			ldo_en   <= 1'b0;
			boost_en <= 1'b0;
			aux_vsel <= AUX_RST;
			aux_en   <= 1'b0;
			chg_man  <= 1'b0;
			chg_i    <= '0;
		end else if (ce_i) begin
			if (loading) begin
				src_sel  <= strap;
				boost_en <= strap;
				ldo_en   <= 1'b1;
			end else if (running) begin
				if (wr_ctrl0) begin
					src_sel  <= w_src;
					boost_en <= dat_i[B_BOOST_EN];
					aux_vsel <= dat_i[B_AUX_VHI:B_AUX_VLO];
					chg_man  <= dat_i[B_CHG_MAN];
				end
				if (wr_ctrl1)
					chg_i <= dat_i[B_CHG_IHI:B_CHG_ILO];
				if (force_en | otg_req)
					ldo_en <= 1'b1;
				else if (wr_ctrl0)
					ldo_en <= dat_i[B_LDO_EN];
				if (otg_req)
					aux_en <= 1'b1;
				else if (wr_ctrl0)
					aux_en <= dat_i[B_AUX_EN];
			end
		end
	end

	// ------------------------------------------------------------
	// Supply path
	// ------------------------------------------------------------
	// Host mode needs cable voltage; OTG runs from the boost
	wire feed_ok  = src_sel | bus_ok;
	wire next_on  = running & ldo_en & feed_ok & ~ovv;
	wire next_sw  = running & drive & src_sel;
	wire next_bst = running & boost_en;
	wire next_src = src_sel;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			phy_ldo_on_o             <= 1'b0;
			phy_ldo_src_boost_o      <= 1'b0;
			boost_switch_close_o     <= 1'b0;
			boost_converter_en_o     <= 1'b0;
			aux_phy_ldo_on_o         <= 1'b0;
			aux_ldo_voltage_select_o <= AUX_RST;
			charger_manual_mode_o    <= 1'b0;
			charge_current_o         <= '0;
		end else if (ce_i) begin
			phy_ldo_on_o             <= next_on;
			phy_ldo_src_boost_o      <= next_src;
			boost_switch_close_o     <= next_sw;
			boost_converter_en_o     <= next_bst;
			aux_phy_ldo_on_o         <= running & aux_en;
			aux_ldo_voltage_select_o <= aux_vsel;
			charger_manual_mode_o    <= chg_man;
			charge_current_o         <= chg_i;
		end
	end

	// ------------------------------------------------------------
	// Interrupts
	// ------------------------------------------------------------
	logic [N_IRQ-1:0] irq_stat;
	logic [N_IRQ-1:0] irq_mask;
	logic [N_IRQ-1:0] ev;

	// Events are raised in either mode, boost-driven bus included
	assign ev[Q_BUS_RISE] = bus_ok & ~sync_prev[I_BUS_OK];
	assign ev[Q_BUS_FALL] = ~bus_ok & sync_prev[I_BUS_OK];
	assign ev[Q_SESS_UP]  = sess_ok & ~sync_prev[I_SESS_OK];
	assign ev[Q_OVV_UP]   = ovv & ~sync_prev[I_OVV];

	// Read clears only the bits it returned; later events survive
	wire [N_IRQ-1:0] keep = rd_irqs ? (irq_stat & ~dat_o[N_IRQ-1:0]) :
	                                  irq_stat;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_stat <= '0;
			irq_mask <= '0;
		end else if (ce_i) begin
			irq_stat <= keep | (running ? ev : '0);
			if (wr_irqm)
				irq_mask <= dat_i[N_IRQ-1:0];
		end
	end

	assign irq_o = |(irq_stat & irq_mask);

	// ------------------------------------------------------------
	// Read mux and acknowledge
	// ------------------------------------------------------------
	logic [31:0] rd_ctrl;
	logic [31:0] rd_stat;
	logic [31:0] rd_mux;

	always_comb begin
		rd_ctrl                      = '0;
		rd_ctrl[B_SRC_SEL]           = src_sel;
		rd_ctrl[B_LDO_EN]            = ldo_en;
		rd_ctrl[B_BOOST_EN]          = boost_en;
		rd_ctrl[B_AUX_VHI:B_AUX_VLO] = aux_vsel;
		rd_ctrl[B_AUX_EN]            = aux_en;
		rd_ctrl[B_CHG_MAN]           = chg_man;
		rd_ctrl[B_CHG_IHI:B_CHG_ILO] = chg_i;
		rd_stat                      = '0;
		rd_stat[N_IN-1:0]            = sync_b;
		rd_stat[B_SW_CLOSE]          = boost_switch_close_o;
		rd_stat[B_LDO_ON]            = phy_ldo_on_o;
		rd_stat[B_RUN]               = running;
	end

	assign rd_mux = hit_ctrl ? rd_ctrl :
	                hit_stat ? rd_stat :
	                hit_irqs ? {{(32-N_IRQ){1'b0}}, irq_stat} :
	                hit_irqm ? {{(32-N_IRQ){1'b0}}, irq_mask} :
	                32'h0000_0000;

	// Ack rises one cycle after the request and lasts one cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack   <= 1'b0;
			dat_o <= '0;
		end else if (ce_i) begin
			ack <= req & ~ack;
			if (req & ~ack & ~we_i)
				dat_o <= rd_mux;
		end
	end

	assign ack_o = ack;

endmodule

// ### verification/usc_sva.sv
// Checker for usc_top: bus handshake and supply-gating relations.
// Assumes ce_i is high while the bus or pins move; pins pass 2 flops.
`timescale 1ns/10ps
module usc_sva
	import usc_pkg::*;
(
	// Clock and reset
	input wire logic                      clk_i,
	input wire logic                      rst_i,
	// Wishbone
	input wire logic                      cyc_i,
	input wire logic                      stb_i,
	input wire logic                      we_i,
	input wire logic [usc_pkg::ADR_W-1:0] adr_i,
	input wire logic [3:0]                sel_i,
	input wire logic [31:0]               dat_i,
	input wire logic                      ack_o,
	// Pins
	input wire logic                      cable_bus_valid_i,
	input wire logic                      session_valid_i,
	input wire logic                      bus_overvoltage_i,
	input wire logic                      bus_drive_enable_pin_i,
	// Supply controls
	input wire logic                      phy_ldo_src_boost_o,
	input wire logic                      phy_ldo_on_o,
	input wire logic                      boost_switch_close_o,
	input wire logic                      aux_phy_ldo_on_o,
	input wire logic                      irq_o
);
	logic [3:0] run_cnt;
	logic       run_ok;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// Counts edges since reset so control writes are known to be taken
	always_ff @(posedge clk_i) begin
		if (rst_i)
			run_cnt <= 4'h0;
		else if (run_cnt != 4'h8)
			run_cnt <= run_cnt + 4'h1;
	end
	assign run_ok = (run_cnt == 4'h8);

	sequence req;
		cyc_i && stb_i && !ack_o;
	endsequence
	sequence quiet;
		$stable({cable_bus_valid_i, session_valid_i, bus_overvoltage_i})[*5];
	endsequence
	sequence stat_read;
		cyc_i && stb_i && ack_o && !we_i && adr_i == OFS_IRQ_STAT;
	endsequence

	a_ack_next: assert property (req |=> ack_o)
		else $error("ack missing after request");
	a_ack_pulse: assert property (ack_o |=> !ack_o)
		else $error("ack longer than one cycle");
	a_switch_pin: assert property (
		boost_switch_close_o |-> $past(bus_drive_enable_pin_i, 3))
		else $error("switch closed without drive pin");
	a_switch_otg: assert property (
		boost_switch_close_o |-> phy_ldo_src_boost_o ||
			$past(phy_ldo_src_boost_o))
		else $error("switch closed in host mode");
	a_ovv_cuts_ldo: assert property (
		$past(bus_overvoltage_i, 3) |-> !phy_ldo_on_o)
		else $error("PHY LDO on during over-voltage");
	a_ldo_has_source: assert property (
		phy_ldo_on_o |-> $past(cable_bus_valid_i, 3) ||
			phy_ldo_src_boost_o || $past(phy_ldo_src_boost_o))
		else $error("PHY LDO on with no supply");
	a_otg_auto_en: assert property (
		run_ok && cyc_i && stb_i && we_i && ack_o && adr_i == OFS_CTRL &&
			sel_i[0] && dat_i[B_SRC_SEL] && !phy_ldo_src_boost_o |->
			##2 (aux_phy_ldo_on_o && phy_ldo_src_boost_o))
		else $error("OTG select did not enable LDOs");
	a_irq_cleared: assert property (quiet ##0 stat_read |=> !irq_o)
		else $error("irq still high after status read");
endmodule

bind usc_top usc_sva chk_u (.*);

// ### verification/usc_cable_host.sv
// Cable-side partner: a host or the boost raises the bus when attached.
// Assumes the bench changes attach and fault just after a clock edge.
`timescale 1ns/10ps
module usc_cable_host (
	// Clock and requests
	input  wire logic clk_i,
	input  wire logic attach_i,
	input  wire logic fault_i,
	// Comparator levels
	output logic      cable_bus_valid_o,
	output logic      session_valid_o,
	output logic      bus_overvoltage_o
);
	initial begin
		cable_bus_valid_o = 1'b0;
		session_valid_o = 1'b0;
		bus_overvoltage_o = 1'b0;
	end
	// Session threshold trips one cycle before bus valid
	always @(posedge clk_i) begin
		session_valid_o <= attach_i;
		cable_bus_valid_o <= session_valid_o & attach_i;
		bus_overvoltage_o <= attach_i & fault_i;
	end
endmodule

// ### verification/tb_usc_top.sv
// Self-checking bench for usc_top with a cable-side partner.
// Assumes the package and design are compiled before this file.
`timescale 1ns/10ps
module tb_usc_top;
	import usc_pkg::*;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        ce_i = 1'b1;
	logic        cyc_i = 1'b0;
	logic        stb_i = 1'b0;
	logic        we_i = 1'b0;
	logic [3:0]  adr_i = 4'h0;
	logic [3:0]  sel_i = 4'hF;
	logic [31:0] dat_i = 32'h0000_0000;
	logic        power_up_strap_two_gnd_i = 1'b0;
	logic        bus_drive_enable_pin_i = 1'b0;
	logic        system_reset_n_i = 1'b1;
	logic        attach = 1'b0;
	logic        fault = 1'b0;
	logic [31:0] dat_o, rd;
	logic        ack_o, cable_bus_valid_i, session_valid_i, bus_overvoltage_i;
	logic        phy_ldo_src_boost_o, phy_ldo_on_o, boost_switch_close_o;
	logic        boost_converter_en_o, aux_phy_ldo_on_o, irq_o;
	logic        charger_manual_mode_o;
	logic [1:0]  aux_ldo_voltage_select_o;
	logic [3:0]  charge_current_o;
	int          err_total = 0;
	int          total_checks = 0;

	initial forever #2 clk_i = ~clk_i;

	usc_top dut_u (.clk_i, .rst_i, .ce_i, .cyc_i, .stb_i, .we_i, .adr_i,
		.sel_i, .dat_i, .dat_o, .ack_o, .cable_bus_valid_i, .session_valid_i,
		.bus_overvoltage_i, .power_up_strap_two_gnd_i, .bus_drive_enable_pin_i,
		.system_reset_n_i, .phy_ldo_src_boost_o, .phy_ldo_on_o,
		.boost_switch_close_o, .boost_converter_en_o, .aux_phy_ldo_on_o,
		.aux_ldo_voltage_select_o, .charger_manual_mode_o, .charge_current_o,
		.irq_o);
	usc_cable_host host_u (.clk_i, .attach_i(attach), .fault_i(fault),
		.cable_bus_valid_o(cable_bus_valid_i),
		.session_valid_o(session_valid_i),
		.bus_overvoltage_o(bus_overvoltage_i));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	task automatic wb(input logic w, input logic [3:0] a,
		input logic [31:0] d, input logic [3:0] s = 4'hF);
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		sel_i <= s;
		do begin
			@(posedge clk_i);
		end while (ack_o !== 1'b1);
		rd = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
	endtask
	// Supply outputs packed as {source, ldo, boost, switch}
	function automatic logic [31:0] outs();
		return {28'h0, phy_ldo_src_boost_o, phy_ldo_on_o,
			boost_converter_en_o, boost_switch_close_o};
	endfunction
	task automatic cold(input logic strap);
		@(posedge clk_i);
		rst_i <= 1'b1;
		power_up_strap_two_gnd_i <= strap;
		tick(12);
		rst_i <= 1'b0;
		tick(10);
	endtask

	task automatic t_open();
		cold(1'b0);
		wb(0, OFS_CTRL, 0);
		chk(rd, 32'h0000_0002);
		wb(0, OFS_STATUS, 0);
		chk(rd, 32'h0000_0080);
		chk(outs(), 32'h0000_0000);
		wb(1, 4'h2, 32'hFFFF_FFFF);
		wb(0, 4'h2, 0);
		chk(rd, 32'h0000_0000);
	endtask
	task automatic t_irq();
		wb(1, OFS_IRQ_MASK, 0);
		attach <= 1'b1;
		tick(8);
		chk({31'h0, irq_o}, 32'h0000_0000);
		chk(outs(), 32'h0000_0004);
		wb(1, OFS_IRQ_MASK, 32'h0000_000F);
		tick(1);
		chk({31'h0, irq_o}, 32'h0000_0001);
		wb(0, OFS_IRQ_STAT, 0);
		chk(rd, 32'h0000_0005);
		tick(1);
		chk({31'h0, irq_o}, 32'h0000_0000);
	endtask
	task automatic t_force();
		wb(1, OFS_CTRL, 0);
		tick(2);
		chk(outs(), 32'h0000_0000);
		attach <= 1'b0;
		tick(8);
		wb(0, OFS_CTRL, 0);
		chk(rd, 32'h0000_0002);
		attach <= 1'b1;
		tick(8);
		wb(1, OFS_CTRL, 0);
		system_reset_n_i <= 1'b0;
		tick(4);
		system_reset_n_i <= 1'b1;
		wb(0, OFS_CTRL, 0);
		chk(rd, 32'h0000_0002);
	endtask
	task automatic t_otg();
		wb(1, OFS_CTRL, 32'h0000_0040);
		wb(1, OFS_CTRL, 32'h0000_0041);
		tick(2);
		wb(0, OFS_CTRL, 0);
		chk(rd, 32'h0000_0063);
		chk({26'h0, aux_phy_ldo_on_o, charger_manual_mode_o,
			charge_current_o}, 32'h0000_0030);
		bus_drive_enable_pin_i <= 1'b1;
		tick(5);
		chk(outs(), 32'h0000_000D);
		wb(1, OFS_CTRL, 32'h0000_0067);
		tick(2);
		chk(outs(), 32'h0000_000F);
		wb(0, OFS_IRQ_STAT, 0);
		attach <= 1'b0;
		tick(8);
		attach <= 1'b1;
		tick(8);
		wb(0, OFS_IRQ_STAT, 0);
		chk(rd, 32'h0000_0007);
		chk(outs(), 32'h0000_000F);
		wb(1, OFS_CTRL, 32'h0000_0065);
		tick(2);
		chk(outs(), 32'h0000_000B);
		wb(1, OFS_CTRL, 32'h0000_0040);
		tick(5);
		chk(outs(), 32'h0000_0000);
		wb(1, OFS_CTRL, 32'h0000_0042);
		tick(2);
		chk(outs(), 32'h0000_0004);
		bus_drive_enable_pin_i <= 1'b0;
	endtask
	task automatic t_ovv_aux();
		fault <= 1'b1;
		tick(6);
		chk(outs(), 32'h0000_0000);
		fault <= 1'b0;
		tick(6);
		chk(outs(), 32'h0000_0004);
		for (int i = 0; i < 4; i++) begin
			wb(1, OFS_CTRL, {27'h0, i[1:0], 3'h2});
			tick(2);
			chk({30'h0, aux_ldo_voltage_select_o}, {30'h0, i[1:0]});
		end
		wb(1, OFS_CTRL, 32'h0000_0F01, 4'h2);
		wb(0, OFS_CTRL, 0);
		chk(rd, 32'h0000_0F1A);
		chk({28'h0, charge_current_o}, 32'h0000_000F);
	endtask
	task automatic t_strap();
		attach <= 1'b0;
		ce_i <= 1'b0;
		cold(1'b1);
		// Clock enable low must hold the sequencer in cold start
		chk(outs(), 32'h0000_0000);
		ce_i <= 1'b1;
		tick(10);
		wb(0, OFS_CTRL, 0);
		chk(rd, 32'h0000_0007);
		chk(outs(), 32'h0000_000E);
	endtask

	task automatic close_out();
		$display("Comparisons %0d, mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// Ends a hung handshake or scenario
	initial begin
		#20000;
		err_total++;
		close_out();
	end
	initial begin
		t_open();
		t_irq();
		t_force();
		t_otg();
		t_ovv_aux();
		t_strap();
		close_out();
	end
endmodule
